// ==== bench/far_side_sources.sv ====
`timescale 1ns/1ps
`default_nettype none
module far_side_sources (
	// System
	input  wire logic clk,
	// Clock and gate sources
	output logic      external_clock_pin,
	output logic      secondary_osc_input,
	output logic      low_freq_internal_osc,
	output logic      gate_pin,
	output logic      companion_timer_ovf,
	output logic      comparator1_out,
	output logic      comparator2_out
);
	logic [3:0] lf_cnt;
	logic [3:0] comp_cnt;

	initial begin
		external_clock_pin    = 1'b1;
		secondary_osc_input   = 1'b1;
		low_freq_internal_osc = 1'b0;
		gate_pin              = 1'b0;
		comparator1_out       = 1'b0;
		comparator2_out       = 1'b0;
		lf_cnt                = 4'h0;
		comp_cnt              = 4'h0;
	end

	// Slow oscillator runs free, period of ten system clocks
	always @(posedge clk) begin
		lf_cnt <= (lf_cnt == 4'h4) ? 4'h0 : lf_cnt + 4'h1;
		if (lf_cnt == 4'h4) begin
			low_freq_internal_osc <= ~low_freq_internal_osc;
		end
	end

	// Short companion period: one-cycle pulse at each wrap
	always @(posedge clk) begin
		comp_cnt <= comp_cnt + 4'h1;
	end
	assign companion_timer_ovf = (comp_cnt == 4'hf);

	// Levels: {comparator 2, comparator 1, gate pin}
	task automatic set_levels(input logic [2:0] v);
		@(posedge clk);
		gate_pin        <= v[0];
		comparator1_out <= v[1];
		comparator2_out <= v[2];
	endtask

	// Pulses end high; the line stands still between frames
	task automatic pulses(input logic use_osc, input int n);
		repeat (n) begin
			@(posedge clk);
			if (use_osc) secondary_osc_input <= 1'b0;
			else external_clock_pin <= 1'b0;
			repeat (4) @(posedge clk);
			if (use_osc) secondary_osc_input <= 1'b1;
			else external_clock_pin <= 1'b1;
			repeat (3) @(posedge clk);
		end
	endtask
endmodule // far_side_sources
`default_nettype wire

// ==== bench/test_gated_sixteen_bit_timer.sv ====
`timescale 1ns/1ps
`include "gated_timer_defs.svh"
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
	bad_count++; $display("unexpected at %0t: got %h exp %h", $time, \
	(got), (exp)); end end
module test_gated_sixteen_bit_timer;
	import gated_timer_pkg::*;
	typedef struct {logic [7:0] v; logic [7:0] tol;} note_t;
	logic       clk, srst, ce, wr, rd, rd_q, sleep;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, tc, diff;
	logic       ext_pin, sosc, lfosc, gpin, comp_ovf, cmp1, cmp2;
	logic       overflow_flag, secondary_osc_enable, wake_request;
	clk_src_t   active_clock_source;
	note_t      exp_q[$];
	note_t      n;
	logic [15:0] r;
	int         bad_count, n_compared;

	gated_sixteen_bit_timer gated_sixteen_bit_timer_i (.clk(clk),
		.srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .external_clock_pin(ext_pin),
		.secondary_osc_input(sosc), .low_freq_internal_osc(lfosc),
		.gate_pin(gpin), .companion_timer_ovf(comp_ovf),
		.comparator1_out(cmp1), .comparator2_out(cmp2), .sleep(sleep),
		.overflow_flag(overflow_flag),
		.secondary_osc_enable(secondary_osc_enable),
		.wake_request(wake_request),
		.active_clock_source(active_clock_source));
	far_side_sources far_side_sources_i (.clk(clk),
		.external_clock_pin(ext_pin), .secondary_osc_input(sosc),
		.low_freq_internal_osc(lfosc), .gate_pin(gpin),
		.companion_timer_ovf(comp_ovf), .comparator1_out(cmp1),
		.comparator2_out(cmp2));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	task automatic rreg(input logic [2:0] a, input logic [7:0] v,
		input logic [7:0] tol);
		@(posedge clk);
		exp_q.push_back('{v, tol});
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
	endtask

	task automatic clr;
		wreg(`ADDR_COUNT_LO, 8'h00);
		wreg(`ADDR_COUNT_HI, 8'h00);
	endtask

	// Timer on for exactly n cycles between the two taken writes
	task automatic run(input int n);
		wreg(`ADDR_TIMER_CTL, tc | 8'h01);
		repeat (n - 2) @(posedge clk);
		wreg(`ADDR_TIMER_CTL, tc & 8'hfe);
	endtask

	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Read data stands in the cycle after the strobe only
	always @(posedge clk) rd_q <= rd && ce;
	always @(negedge clk) begin
		if (rd_q) begin
			n = exp_q.pop_front();
			diff = rdata - n.v;
			if (n.tol == 8'h00) `CHK(rdata, n.v)
			else `CHK(diff <= n.tol, 1'b1)
		end
	end

	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		wrap_up();
	end

	initial begin
		srst = 1'b1; ce = 1'b1; addr = 3'h0; wdata = 8'h00;
		wr = 1'b0; rd = 1'b0; sleep = 1'b0; tc = 8'h00;
		bad_count = 0; n_compared = 0;
		r = 16'($urandom(68209));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (int a = 0; a < 6; a++) rreg(a[2:0], 8'h00, 8'h00);
		repeat (4) begin
			r = 16'($urandom);
			wreg(`ADDR_COUNT_LO, r[7:0]);
			wreg(`ADDR_COUNT_HI, r[15:8]);
			rreg(`ADDR_COUNT_LO, r[7:0], 8'h00);
			rreg(`ADDR_COUNT_HI, r[15:8], 8'h00);
		end
		wreg(`ADDR_GATE_CTL, 8'h80);
		wreg(`ADDR_TIMER_CTL, 8'h40);
		repeat (40) @(posedge clk);
		rreg(`ADDR_COUNT_LO, r[7:0], 8'h00);
		wreg(`ADDR_GATE_CTL, 8'h00);
		for (int p = 0; p < 4; p++) begin
			tc = {2'b01, p[1:0], 4'h0};
			clr();
			run(64 << p);
			rreg(`ADDR_COUNT_LO, 8'h40, 8'h00);
			rreg(`ADDR_COUNT_HI, 8'h00, 8'h00);
		end
		tc = 8'h70;
		clr();
		run(4);
		wreg(`ADDR_COUNT_LO, 8'h00);
		run(4);
		rreg(`ADDR_COUNT_LO, 8'h00, 8'h00);
		// Clock enable low for ten edges freezes the count
		tc = 8'h40;
		clr();
		fork
			run(64);
			begin
				repeat (20) @(posedge clk);
				ce <= 1'b0;
				repeat (10) @(posedge clk);
				ce <= 1'b1;
			end
		join
		rreg(`ADDR_COUNT_LO, 8'h36, 8'h00);
		tc = 8'h00;
		clr();
		run(256);
		rreg(`ADDR_COUNT_LO, 8'h3f, 8'h02);
		tc = 8'h40;
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 4; s++) begin
				if (s == 1) continue;
				wreg(`ADDR_GATE_CTL,
					{2'b10 | p[1:0], 2'b00, p[0], p[0], s[1:0]});
				far_side_sources_i.set_levels({3{~p[0]}});
				repeat (8) @(posedge clk);
				clr();
				run(64);
				rreg(`ADDR_COUNT_LO, 8'h00, 8'h00);
				far_side_sources_i.set_levels({3{p[0]}});
				repeat (8) @(posedge clk);
				clr();
				run(64);
				rreg(`ADDR_COUNT_LO, 8'h40, 8'h00);
			end
		end
		wreg(`ADDR_GATE_CTL, 8'hc1);
		clr();
		run(256);
		rreg(`ADDR_COUNT_LO, 8'h0f, 8'h02);
		wreg(`ADDR_GATE_CTL, 8'h00);
		wreg(`ADDR_COUNT_HI, 8'hff);
		wreg(`ADDR_COUNT_LO, 8'hf0);
		run(32);
		rreg(`ADDR_COUNT_LO, 8'h10, 8'h00);
		rreg(`ADDR_COUNT_HI, 8'h00, 8'h00);
		`CHK(overflow_flag, 1'b1)
		rreg(`ADDR_STATUS, 8'h01, 8'h00);
		sleep <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(wake_request, 1'b1)
		sleep <= 1'b0;
		wreg(`ADDR_STATUS, 8'h01);
		rreg(`ADDR_STATUS, 8'h00, 8'h00);
		for (int s = 0; s < 2; s++) begin
			tc = {4'h8, 1'b0, s[0], 2'b00};
			clr();
			sleep <= s[0];
			wreg(`ADDR_TIMER_CTL, tc | 8'h01);
			far_side_sources_i.pulses(1'b0, 5);
			repeat (8) @(posedge clk);
			wreg(`ADDR_TIMER_CTL, tc);
			sleep <= 1'b0;
			rreg(`ADDR_COUNT_LO, 8'h05, 8'h00);
		end
		tc = 8'h8c;
		clr();
		wreg(`ADDR_TIMER_CTL, tc | 8'h01);
		@(negedge clk);
		`CHK(secondary_osc_enable, 1'b1)
		`CHK(active_clock_source, CS_PIN)
		far_side_sources_i.pulses(1'b1, 3);
		repeat (8) @(posedge clk);
		wreg(`ADDR_TIMER_CTL, tc);
		rreg(`ADDR_COUNT_LO, 8'h03, 8'h00);
		// Oscillator settling wait: preset, then flag after 1024 edges
		wreg(`ADDR_COUNT_HI, 8'hfc);
		wreg(`ADDR_COUNT_LO, 8'h00);
		wreg(`ADDR_TIMER_CTL, tc | 8'h01);
		far_side_sources_i.pulses(1'b1, 1023);
		repeat (8) @(posedge clk);
		`CHK(overflow_flag, 1'b0)
		sleep <= 1'b1;
		far_side_sources_i.pulses(1'b1, 1);
		repeat (8) @(posedge clk);
		`CHK(overflow_flag, 1'b1)
		`CHK(wake_request, 1'b1)
		sleep <= 1'b0;
		wreg(`ADDR_TIMER_CTL, tc);
		tc = 8'hc0;
		clr();
		run(400);
		rreg(`ADDR_COUNT_LO, 8'h27, 8'h02);
		repeat (4) @(posedge clk);
		wrap_up();
	end
endmodule // test_gated_sixteen_bit_timer
`default_nettype wire

// ==== hw/gated_sixteen_bit_timer.sv ====
`timescale 1ns/1ps
`include "gated_timer_defs.svh"
`default_nettype none
module gated_sixteen_bit_timer (
	// System
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	// Register port
	input  wire logic [2:0]            addr,
	input  wire logic [7:0]            wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output logic [7:0]                 rdata,
	// Clock and gate sources
	input  wire logic                  external_clock_pin,
	input  wire logic                  secondary_osc_input,
	input  wire logic                  low_freq_internal_osc,
	input  wire logic                  gate_pin,
	input  wire logic                  companion_timer_ovf,
	input  wire logic                  comparator1_out,
	input  wire logic                  comparator2_out,
	input  wire logic                  sleep,
	// Status
	output logic                       overflow_flag,
	output logic                       secondary_osc_enable,
	output logic                       wake_request,
	output gated_timer_pkg::clk_src_t  active_clock_source
);
	import gated_timer_pkg::*;

	logic [7:0]           tc_reg;
	logic [7:0]           gc_reg;
	logic [15:0]          count_reg;
	logic [15:0]          count_next;
	presc_t               presc_reg;
	presc_t               presc_mask;
	logic [1:0]           quarter_reg;
	logic [`IN_WIDTH-1:0] async_in;
	logic [`IN_WIDTH-1:0] meta_reg;
	logic [`IN_WIDTH-1:0] sync_reg;
	logic                 pin_stage_reg;
	logic                 pin_prev_reg;
	logic                 slow_prev_reg;
	logic                 armed_reg;
	logic                 c1_stage_reg;
	logic                 c2_stage_reg;
	logic [7:0]           rdata_reg;
	logic                 ovf_reg;
	logic                 wake_reg;
	clk_src_t             cs;
	gate_src_t            gss;
	logic                 timer_on;
	logic                 gate_enable;
	logic                 gate_polarity;
	logic                 sync_control;
	logic                 raw_pin_lvl;
	logic                 pin_lvl;
	logic                 src_tick;
	logic                 presc_tick;
	logic                 gate_sel;
	logic                 gate_active;
	logic                 sleep_ok;
	logic                 run;
	logic                 inc;
	logic                 wr_lo;
	logic                 wr_hi;
	logic                 cnt_write;
	logic                 ovf_set;
	logic                 ovf_clr;

	assign cs            = clk_src_t'(tc_reg[`TC_CS_HI:`TC_CS_LO]);
	assign gss           = gate_src_t'(gc_reg[`GC_GSS_HI:`GC_GSS_LO]);
	assign timer_on      = tc_reg[`TC_ON];
	assign sync_control  = tc_reg[`TC_SYNC];
	assign gate_enable   = gc_reg[`GC_GE];
	assign gate_polarity = gc_reg[`GC_POL];
	assign wr_lo         = ce & wr & (addr == `ADDR_COUNT_LO);
	assign wr_hi         = ce & wr & (addr == `ADDR_COUNT_HI);
	assign cnt_write     = wr_lo | wr_hi;

	// Register writes
	always_ff @(posedge clk) begin
		if (srst) begin
			tc_reg <= `TC_RESET;
			gc_reg <= `GC_RESET;
		end else if (ce && wr) begin
			if (addr == `ADDR_TIMER_CTL)
				tc_reg <= wdata;
			if (addr == `ADDR_GATE_CTL)
				gc_reg <= wdata;
		end
	end

	// Every clock and gate source except companion_timer_ovf passes two flip-flops before use
	assign async_in = {comparator2_out, comparator1_out, gate_pin,
		low_freq_internal_osc, secondary_osc_input, external_clock_pin};

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else if (ce) begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	// Pin or crystal source, optional extra system-clock stage
	assign raw_pin_lvl = tc_reg[`TC_OSC_EN] ? sync_reg[`IN_SOSC]
		: sync_reg[`IN_PIN_CLK];
	assign pin_lvl = sync_control ? raw_pin_lvl : pin_stage_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_stage_reg <= 1'b0;
			pin_prev_reg  <= 1'b0;
			slow_prev_reg <= 1'b0;
			quarter_reg   <= 2'h0;
		end else if (ce) begin
			pin_stage_reg <= raw_pin_lvl;
			pin_prev_reg  <= pin_lvl;
			slow_prev_reg <= sync_reg[`IN_LFOSC];
			quarter_reg   <= quarter_reg + 2'h1;
		end
	end

	// A low level must be seen before the first counted rising edge
	always_ff @(posedge clk) begin
		if (srst) begin
			armed_reg <= 1'b0;
		end else if (ce) begin
			if (cnt_write || !timer_on)
				armed_reg <= 1'b0;
			else if (!pin_lvl)
				armed_reg <= 1'b1;
		end
	end

	always_comb begin
		case (cs)
			CS_QUARTER: src_tick = (quarter_reg == `QUARTER_LAST);
			CS_SYSCLK:  src_tick = 1'b1;
			CS_PIN:     src_tick = pin_lvl & ~pin_prev_reg & armed_reg;
			CS_SLOWOSC: src_tick = sync_reg[`IN_LFOSC] & ~slow_prev_reg;
			default:    src_tick = 1'b0;
		endcase
	end

	always_comb begin
		case (tc_reg[`TC_PS_HI:`TC_PS_LO])
			2'h0:    presc_mask = 3'h0;
			2'h1:    presc_mask = 3'h1;
			2'h2:    presc_mask = 3'h3;
			2'h3:    presc_mask = 3'h7;
			default: presc_mask = 3'h0;
		endcase
	end

	// Comparator outputs optionally resampled on the count clock
	always_ff @(posedge clk) begin
		if (srst) begin
			c1_stage_reg <= 1'b0;
			c2_stage_reg <= 1'b0;
		end else if (ce && src_tick) begin
			c1_stage_reg <= sync_reg[`IN_COMP1];
			c2_stage_reg <= sync_reg[`IN_COMP2];
		end
	end

	always_comb begin
		case (gss)
			GS_PIN:       gate_sel = sync_reg[`IN_GATE];
			GS_COMPANION: gate_sel = companion_timer_ovf;
			GS_COMP1:     gate_sel = gc_reg[`GC_C1_SYNC] ? c1_stage_reg
				: sync_reg[`IN_COMP1];
			GS_COMP2:     gate_sel = gc_reg[`GC_C2_SYNC] ? c2_stage_reg
				: sync_reg[`IN_COMP2];
			default:      gate_sel = 1'b0;
		endcase
	end

	assign gate_active = gate_polarity ? gate_sel : ~gate_sel;
	// Only the raw pin source keeps counting while the core sleeps
	assign sleep_ok    = sync_control & (cs == CS_PIN);
	assign run = ce & timer_on & (~gate_enable | gate_active)
		& (~sleep | sleep_ok);
	assign presc_tick  = src_tick & (presc_reg == presc_mask);
	assign inc         = run & presc_tick;

	always_ff @(posedge clk) begin
		if (srst) begin
			presc_reg <= 3'h0;
		end else if (ce) begin
			if (cnt_write)
				presc_reg <= 3'h0;
			else if (run && src_tick)
				presc_reg <= presc_tick ? 3'h0 : presc_reg + 3'h1;
		end
	end

	// A write takes precedence over a coinciding increment only in the byte it writes
	always_comb begin
		count_next = count_reg;
		if (inc)
			count_next = count_reg + 16'h0001;
		if (wr_lo)
			count_next[7:0] = wdata;
		if (wr_hi)
			count_next[15:8] = wdata;
	end

	always_ff @(posedge clk) begin
		if (srst)
			count_reg <= `COUNT_RESET;
		else if (ce)
			count_reg <= count_next;
	end

	// Sticky overflow flag, write one to clear, set wins
	assign ovf_set = inc & (count_reg == `COUNT_MAX) & ~cnt_write;
	assign ovf_clr = ce & wr & (addr == `ADDR_STATUS) & wdata[`ST_OVF];

	always_ff @(posedge clk) begin
		if (srst) begin
			ovf_reg  <= 1'b0;
			wake_reg <= 1'b0;
		end else if (ce) begin
			if (ovf_set)
				ovf_reg <= 1'b1;
			else if (ovf_clr)
				ovf_reg <= 1'b0;
			wake_reg <= sleep & (ovf_set | ovf_reg);
		end
	end

	// Read data stand for one cycle only
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 8'h00;
		end else if (ce) begin
			if (rd) begin
				case (addr)
					`ADDR_COUNT_LO:  rdata_reg <= count_reg[7:0];
					`ADDR_COUNT_HI:  rdata_reg <= count_reg[15:8];
					`ADDR_TIMER_CTL: rdata_reg <= tc_reg;
					`ADDR_GATE_CTL:  rdata_reg <= gc_reg;
					`ADDR_STATUS:    rdata_reg <= {7'h00, ovf_reg};
					default:         rdata_reg <= 8'h00;
				endcase
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end

	assign rdata                = rdata_reg;
	assign overflow_flag        = ovf_reg;
	assign secondary_osc_enable = tc_reg[`TC_OSC_EN];
	assign wake_request         = wake_reg;
	assign active_clock_source  = cs;

	default clocking dcb @(posedge clk); endclocking
	default disable iff (srst);

	AST_WRITE_LOW: assert property (
		wr_lo && !wr_hi |=> count_reg[7:0] == $past(wdata))
		else $error("low byte write not applied");

	AST_WRITE_HIGH: assert property (
		wr_hi |=> count_reg[15:8] == $past(wdata))
		else $error("high byte write not applied");

	AST_OFF_HOLDS: assert property (
		ce && !timer_on && !cnt_write |=> count_reg == $past(count_reg))
		else $error("count moved while timer off");

	AST_FREE_RUN: assert property (
		ce && timer_on && !gate_enable && cs == CS_SYSCLK && !sleep
		&& presc_mask == 3'h0 && !cnt_write
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("system clock source missed an increment");

	AST_QUARTER_SPACING: assert property (
		inc && cs == CS_QUARTER && presc_mask == 3'h0 |=> !inc [*3])
		else $error("quarter clock counted too often");

	AST_DIV8_SPACING: assert property (
		inc && presc_mask == 3'h7 && !cnt_write |=> !inc [*7])
		else $error("divide by eight counted too often");

	AST_PRESC_CLEARED: assert property (
		cnt_write |=> presc_reg == 3'h0)
		else $error("prescaler not cleared by count write");

	AST_PIN_REARM: assert property (
		cnt_write && cs == CS_PIN |=> !inc)
		else $error("pin edge counted before falling edge");

	AST_GATE_HOLDS: assert property (
		ce && timer_on && gate_enable && !gate_active && !cnt_write
		|=> count_reg == $past(count_reg))
		else $error("count moved while gate inactive");

	AST_SLEEP_HOLDS: assert property (
		ce && sleep && !sleep_ok && !cnt_write
		|=> count_reg == $past(count_reg))
		else $error("count moved in sleep without raw pin mode");

	AST_ROLLOVER: assert property (
		ovf_set |=> overflow_flag && count_reg == `COUNT_RESET)
		else $error("rollover did not set flag and wrap");

	AST_FLAG_STICKY: assert property (
		overflow_flag && !ovf_clr |=> overflow_flag)
		else $error("overflow flag dropped without clear");

	AST_FLAG_CLEAR: assert property (
		ovf_clr && !ovf_set |=> !overflow_flag)
		else $error("overflow flag not cleared");

	AST_GATE_POLARITY: assert property (
		ce && timer_on && gate_enable && gate_sel == gate_polarity
		&& cs == CS_SYSCLK && !sleep && presc_mask == 3'h0
		&& !cnt_write
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("active gate level did not count");

	AST_READ_LOW: assert property (
		ce && rd && addr == `ADDR_COUNT_LO
		|=> rdata == $past(count_reg[7:0]))
		else $error("count low byte read wrong");

	AST_READ_HIGH: assert property (
		ce && rd && addr == `ADDR_COUNT_HI
		|=> rdata == $past(count_reg[15:8]))
		else $error("count high byte read wrong");

	AST_WAKE: assert property (
		ce && sleep && overflow_flag |=> wake_request)
		else $error("no wake request with flag set in sleep");

	COV_ROLLOVER: cover property (ovf_set);
	COV_GATED_COUNT: cover property (inc && gate_enable);
	COV_PIN_COUNT: cover property (inc && cs == CS_PIN);
	COV_WAKE: cover property (sleep && ovf_set ##1 wake_request);
	COV_CE_HOLD: cover property (!ce ##1 ce);
endmodule // gated_sixteen_bit_timer
`default_nettype wire

// ==== hw/gated_timer_defs.svh ====
`ifndef GATED_TIMER_DEFS_SVH
`define GATED_TIMER_DEFS_SVH

`define ADDR_COUNT_LO   3'h0
`define ADDR_COUNT_HI   3'h1
`define ADDR_TIMER_CTL  3'h2
`define ADDR_GATE_CTL   3'h3
`define ADDR_STATUS     3'h4

`define TC_CS_HI        7
`define TC_CS_LO        6
`define TC_PS_HI        5
`define TC_PS_LO        4
`define TC_OSC_EN       3
`define TC_SYNC         2
`define TC_ON           0
`define GC_GE           7
`define GC_POL          6
`define GC_C2_SYNC      3
`define GC_C1_SYNC      2
`define GC_GSS_HI       1
`define GC_GSS_LO       0
`define ST_OVF          0

`define TC_RESET        8'h00
`define GC_RESET        8'h00
`define COUNT_RESET     16'h0000
`define COUNT_MAX       16'hffff

`define CLK_PERIOD_NS   10
`define QUARTER_LAST    2'h3

`define IN_PIN_CLK      0
`define IN_SOSC         1
`define IN_LFOSC        2
`define IN_GATE         3
`define IN_COMP1        4
`define IN_COMP2        5
`define IN_WIDTH        6

`endif

// ==== hw/gated_timer_pkg.sv ====
package gated_timer_pkg;
	typedef enum logic [1:0] {
		CS_QUARTER = 2'h0,
		CS_SYSCLK  = 2'h1,
		CS_PIN     = 2'h2,
		CS_SLOWOSC = 2'h3
	} clk_src_t;
	typedef enum logic [1:0] {
		GS_PIN       = 2'h0,
		GS_COMPANION = 2'h1,
		GS_COMP1     = 2'h2,
		GS_COMP2     = 2'h3
	} gate_src_t;
	typedef logic [2:0] presc_t;
endpackage
